// [core/ctr_pkg.sv]
// Package: register map, field layout and routing codes for the channel routing block
package ctr_pkg;
	localparam int CTR_NUM_CH = 5;
	localparam int CTR_ADDR_W = 8;
	// Byte offsets; each channel takes a block of four words, three of them used
	localparam logic [7:0] CTR_CH_BASE = 8'h00;
	localparam logic [7:0] CTR_CH_STRIDE = 8'h10;
	localparam logic [7:0] CTR_OFF_CTRL = 8'h00;
	localparam logic [7:0] CTR_OFF_LOW = 8'h04;
	localparam logic [7:0] CTR_OFF_HIGH = 8'h08;
	localparam logic [7:0] CTR_OFF_TSEL = 8'h50;
	localparam logic [7:0] CTR_OFF_ODC = 8'h54;
	localparam logic [7:0] CTR_OFF_ROUTE = 8'h58;
	// Field positions
	localparam int CTR_ODC_LSB = 2;
	localparam int CTR_ODC_MSB = 6;
	localparam int CTR_TSEL_LSB = 0;
	localparam int CTR_TSEL_W = 4;
	localparam int CTR_CTRL_OUT_BIT = 3;
	localparam int CTR_BYTE_W = 8;
	localparam int CTR_ROUTE_W = 20;
	// Reset values
	localparam logic [7:0] CTR_BYTE_RST = 8'h00;
	localparam logic [3:0] CTR_TSEL_RST = 4'h0;
	localparam logic [4:0] CTR_ODC_RST = 5'h00;
	localparam logic [4:0] CTR_OE_RST = 5'h1F;
	// Timer codes on the routing outputs
	localparam logic [1:0] CTR_TIMER_ONE = 2'h0;
	localparam logic [1:0] CTR_TIMER_TWO = 2'h1;
	localparam logic [1:0] CTR_TIMER_THREE = 2'h2;
	localparam logic [1:0] CTR_TIMER_FOUR = 2'h3;
	// AHB codes
	localparam logic [1:0] CTR_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] CTR_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] CTR_HTRANS_SEQ = 2'h3;
	localparam logic [1:0] CTR_HRESP_OKAY = 2'h0;
	localparam logic [2:0] CTR_HSIZE_WORD = 3'h2;
	localparam logic [31:0] CTR_ZERO_WORD = 32'h0000_0000;
endpackage

// [core/ctr_route.sv]
// Per-channel timer routing from the select bit
`timescale 1ns/100ps
module ctr_route
	import ctr_pkg::*;
(
	input wire logic sel,
	output logic [1:0] cc_timer,
	output logic [1:0] pwm_timer
);
	always_comb begin
		cc_timer = sel ? CTR_TIMER_THREE : CTR_TIMER_ONE;
		pwm_timer = sel ? CTR_TIMER_FOUR : CTR_TIMER_TWO;
	end
endmodule // ctr_route

// [core/ctr_top.sv]
// Top: AHB-Lite register file and timer routing for five channels
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module ctr_top
	import ctr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [4:0] pin_out_en,
	output logic [9:0] cc_timer_sel,
	output logic [9:0] pwm_timer_sel,
	output logic [4:0] open_drain_en
);
	typedef struct packed {
		logic [4:0][7:0] ctrl;
		logic [4:0][7:0] low;
		logic [4:0][7:0] high;
		logic [3:0] tsel;
		logic [4:0] odc;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic [4:0] pin_oe_n;
		logic [9:0] cc_sel;
		logic [9:0] pwm_sel;
		logic [4:0] od_en;
		logic rdy;
		logic [1:0] resp;
	} ctr_state_t;

	ctr_state_t st_reg;
	ctr_state_t st_next;
	logic [4:0] sel_bits;
	logic [9:0] cc_w;
	logic [9:0] pwm_w;
	logic [4:0] out_mode;
	logic take;
	logic [7:0] a;

	// Write hits, decoded from the latched data phase address
	logic [4:0] wr_ctrl_hit;
	logic [4:0] wr_low_hit;
	logic [4:0] wr_high_hit;
	logic wr_tsel_hit;
	logic wr_odc_hit;
	// Read hits, decoded from the live address phase
	logic [4:0] rd_ctrl_hit;
	logic [4:0] rd_low_hit;
	logic [4:0] rd_high_hit;
	logic rd_tsel_hit;
	logic rd_odc_hit;
	logic rd_route_hit;

	// channel one fixed to pair zero
	assign sel_bits = {st_reg.tsel, 1'b0};

	genvar g;
	generate
		for (g = 0; g < CTR_NUM_CH; g++) begin : g_route
			ctr_route u_route (
				.sel(sel_bits[g]),
				.cc_timer(cc_w[2*g +: 2]),
				.pwm_timer(pwm_w[2*g +: 2])
			);
			// Control bit 3 set means compare or PWM, which drives the pin
			assign out_mode[g] = st_reg.ctrl[g][CTR_CTRL_OUT_BIT];
		end
	endgenerate

	// Write decode of the byte registers
	generate
		for (g = 0; g < CTR_NUM_CH; g++) begin : g_wdec
			logic [7:0] ch_base;
			assign ch_base = CTR_CH_BASE + 8'(g) * CTR_CH_STRIDE;
			assign wr_ctrl_hit[g] = (st_reg.wr_addr == ch_base + CTR_OFF_CTRL);
			assign wr_low_hit[g] = (st_reg.wr_addr == ch_base + CTR_OFF_LOW);
			assign wr_high_hit[g] = (st_reg.wr_addr == ch_base + CTR_OFF_HIGH);
		end
	endgenerate

	// Read decode of the byte registers
	generate
		for (g = 0; g < CTR_NUM_CH; g++) begin : g_rdec
			logic [7:0] ch_base;
			assign ch_base = CTR_CH_BASE + 8'(g) * CTR_CH_STRIDE;
			assign rd_ctrl_hit[g] = (a == ch_base + CTR_OFF_CTRL);
			assign rd_low_hit[g] = (a == ch_base + CTR_OFF_LOW);
			assign rd_high_hit[g] = (a == ch_base + CTR_OFF_HIGH);
		end
	endgenerate

	// Write decode of the shared registers
	assign wr_tsel_hit = (st_reg.wr_addr == CTR_OFF_TSEL);
	assign wr_odc_hit = (st_reg.wr_addr == CTR_OFF_ODC);

	// Read decode of the shared registers
	assign rd_tsel_hit = (a == CTR_OFF_TSEL);
	assign rd_odc_hit = (a == CTR_OFF_ODC);
	assign rd_route_hit = (a == CTR_OFF_ROUTE);

	// Request taken in the address phase
	assign take = hsel && hready && (htrans == CTR_HTRANS_NONSEQ || htrans == CTR_HTRANS_SEQ);
	assign a = haddr[CTR_ADDR_W-1:0];

	// Read mux, register updates and pin control
	always_comb begin
		int ch;
		// Loop index defined on every pass
		ch = 0;
		// Start from the held state
		st_next = st_reg;

		// Data phase write lands at the end of the data phase
		if (st_reg.wr_pend) begin
			for (ch = 0; ch < CTR_NUM_CH; ch++) begin
				if (wr_ctrl_hit[ch])
					st_next.ctrl[ch] = hwdata[CTR_BYTE_W-1:0];
				if (wr_low_hit[ch])
					st_next.low[ch] = hwdata[CTR_BYTE_W-1:0];
				if (wr_high_hit[ch])
					st_next.high[ch] = hwdata[CTR_BYTE_W-1:0];
			end
			if (wr_tsel_hit)
				st_next.tsel = hwdata[CTR_TSEL_LSB +: CTR_TSEL_W];
			if (wr_odc_hit)
				st_next.odc = hwdata[CTR_ODC_MSB:CTR_ODC_LSB];
		end

		// A write address phase waits for its data
		st_next.wr_pend = take && hwrite;
		st_next.wr_addr = a;

		// Address phase read, data registered for the data phase
		if (take && !hwrite) begin
			st_next.rdata = CTR_ZERO_WORD; // Unused bits read as zero
			for (ch = 0; ch < CTR_NUM_CH; ch++) begin
				if (rd_ctrl_hit[ch])
					st_next.rdata[CTR_BYTE_W-1:0] = st_next.ctrl[ch];
				if (rd_low_hit[ch])
					st_next.rdata[CTR_BYTE_W-1:0] = st_next.low[ch];
				if (rd_high_hit[ch])
					st_next.rdata[CTR_BYTE_W-1:0] = st_next.high[ch];
			end
			if (rd_tsel_hit)
				st_next.rdata[CTR_TSEL_LSB +: CTR_TSEL_W] = st_next.tsel;
			if (rd_odc_hit)
				st_next.rdata[CTR_ODC_MSB:CTR_ODC_LSB] = st_next.odc;
			// Routing status, read only
			if (rd_route_hit)
				st_next.rdata[CTR_ROUTE_W-1:0] = {st_reg.pwm_sel, st_reg.cc_sel};
		end

		st_next.cc_sel = cc_w;
		st_next.pwm_sel = pwm_w;
		st_next.od_en = st_reg.odc & out_mode;
		// Enable low while driving; open-drain does not change the enable, it only goes out on open_drain_en
		for (ch = 0; ch < CTR_NUM_CH; ch++)
			st_next.pin_oe_n[ch] = ~out_mode[ch];

		// Zero wait states, OKAY answer
		st_next.rdy = 1'b1;
		st_next.resp = CTR_HRESP_OKAY;
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg.ctrl <= {CTR_NUM_CH{CTR_BYTE_RST}};
			st_reg.low <= {CTR_NUM_CH{CTR_BYTE_RST}};
			st_reg.high <= {CTR_NUM_CH{CTR_BYTE_RST}};
			st_reg.tsel <= CTR_TSEL_RST;
			st_reg.odc <= CTR_ODC_RST;
			st_reg.wr_pend <= 1'b0;
			st_reg.wr_addr <= CTR_BYTE_RST;
			st_reg.rdata <= CTR_ZERO_WORD;
			st_reg.pin_oe_n <= CTR_OE_RST;
			// Routing starts on timers one and two
			st_reg.cc_sel <= {CTR_NUM_CH{CTR_TIMER_ONE}};
			st_reg.pwm_sel <= {CTR_NUM_CH{CTR_TIMER_TWO}};
			st_reg.od_en <= CTR_ODC_RST;
			st_reg.rdy <= 1'b1;
			st_reg.resp <= CTR_HRESP_OKAY;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops
	assign hrdata = st_reg.rdata;
	assign hreadyout = st_reg.rdy;
	assign hresp = st_reg.resp;
	assign pin_out_en = st_reg.pin_oe_n;
	assign cc_timer_sel = st_reg.cc_sel;
	assign pwm_timer_sel = st_reg.pwm_sel;
	assign open_drain_en = st_reg.od_en;
endmodule // ctr_top

// [dv/ctr_top_sva.sv]
// Checker: bus and routing relations at the ports of ctr_top
`timescale 1ns/100ps
module ctr_top_chk
	import ctr_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic [1:0] hresp,
	input wire logic [4:0] pin_out_en,
	input wire logic [9:0] cc_timer_sel,
	input wire logic [9:0] pwm_timer_sel,
	input wire logic [4:0] open_drain_en
);
	logic wt;
	logic wt_ts;
	logic wt_od;
	// Write request taken on the bus, and writes that feed the routing outputs
	assign wt = hsel & hready & htrans[1] & hwrite;
	assign wt_ts = wt & (haddr[7:0] == CTR_OFF_TSEL);
	assign wt_od = wt & (haddr[7:0] == CTR_OFF_ODC || haddr[3:0] == 4'h0);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Bus and routing relations
	property p_bus_ok; hreadyout && hresp == 2'h0; endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus answer");
	property p_cc; (cc_timer_sel & 10'h155) == 10'h0; endproperty
	a_cc: assert property (p_cc) else $error("cc class");
	property p_pwm; (pwm_timer_sel & 10'h155) == 10'h155; endproperty
	a_pwm: assert property (p_pwm) else $error("pwm class");
	property p_pair; (cc_timer_sel ^ pwm_timer_sel) == 10'h155; endproperty
	a_pair: assert property (p_pair) else $error("timer pair");
	property p_ch1; cc_timer_sel[1:0] == 2'h0 && pwm_timer_sel[1:0] == 2'h1; endproperty
	a_ch1: assert property (p_ch1) else $error("channel one");
	property p_od; (open_drain_en & pin_out_en) == 5'h0; endproperty
	a_od: assert property (p_od) else $error("od without drive");
	property p_rt; $changed(cc_timer_sel) |-> $past(wt_ts, 3); endproperty
	a_rt: assert property (p_rt) else $error("route change");
	property p_odc; $changed(open_drain_en) |-> $past(wt_od, 3); endproperty
	a_odc: assert property (p_odc) else $error("od change");
	property p_oe; $changed(pin_out_en) |-> $past(wt_od, 3); endproperty
	a_oe: assert property (p_oe) else $error("drive change");
endmodule // ctr_top_chk
bind ctr_top ctr_top_chk u_ctr_top_chk (.clk, .rst, .hsel, .hready, .htrans, .haddr, .hwrite,
	.hreadyout, .hresp, .pin_out_en, .cc_timer_sel, .pwm_timer_sel, .open_drain_en);

// [dv/ctr_top_test.sv]
// Bench: random register traffic and routing checks for ctr_top
`timescale 1ns/100ps
module ctr_top_test
	import ctr_pkg::*;
;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, a, d, r;
	logic [1:0] htrans = 0, hresp;
	logic [2:0] hsize = CTR_HSIZE_WORD;
	logic [4:0] pin_out_en, open_drain_en, ctl = 0, odc = 0;
	logic [9:0] cc_timer_sel, pwm_timer_sel;
	logic [3:0] ts = 0;
	int err_total = 0, tests_run = 0, seed = 3335, ch;
	assign hready = hreadyout;
	always #4 clk = ~clk;
	ctr_top u_ctr_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .pin_out_en, .cc_timer_sel,
		.pwm_timer_sel, .open_drain_en);
	// One single AHB transfer
	task xfer(input logic w, input logic [31:0] ad, wd);
		hsel <= 1;
		htrans <= CTR_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= ad;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= CTR_HTRANS_IDLE;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// Expected timer codes per channel
	function automatic logic [9:0] route(input logic [3:0] t, input logic p);
		logic [4:0] s;
		s = {t, 1'b0};
		for (int i = 0; i < 5; i++)
			route[2*i +: 2] = {s[i], p};
	endfunction
	task give_verdict;
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		for (int k = 0; k < 24; k++) begin
			chk("cc", route(ts, 1'b0), cc_timer_sel);
			chk("pwm", route(ts, 1'b1), pwm_timer_sel);
			chk("drive", ctl ^ 5'h1F, pin_out_en);
			chk("od", odc & ctl, open_drain_en);
			xfer(0, CTR_OFF_ROUTE, 0);
			chk("status", {route(ts, 1'b1), route(ts, 1'b0)}, r);
			ch = k % 5;
			a = 32'(CTR_CH_STRIDE) * 32'(ch);
			for (logic [31:0] o = 0; o < 12; o += 4) begin
				d = $random(seed);
				xfer(1, a + o, d);
				xfer(0, a + o, 0);
				chk("byte", d & 32'hFF, r);
				if (o == 0)
					ctl[ch] = d[3];
			end
			d = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
			xfer(1, CTR_OFF_TSEL, d);
			xfer(0, CTR_OFF_TSEL, 0);
			chk("tsel", d & 32'hF, r);
			ts = d[3:0];
			xfer(1, CTR_OFF_ODC, d);
			xfer(0, CTR_OFF_ODC, 0);
			chk("odc", d & 32'h7C, r);
			odc = d[6:2];
			xfer(1, 32'h0000_00FC, d);
			xfer(0, 32'h0000_00FC, 0);
			chk("unmapped", 0, r);
			repeat (2) @(posedge clk);
		end
		chk("cc", route(ts, 1'b0), cc_timer_sel);
		chk("pwm", route(ts, 1'b1), pwm_timer_sel);
		chk("drive", ctl ^ 5'h1F, pin_out_en);
		chk("od", odc & ctl, open_drain_en);
		give_verdict;
	end
	// Watchdog
	initial begin
		#100000;
		err_total++;
		give_verdict;
	end
endmodule // ctr_top_test
